// ### rtl/fdcr_pkg.sv
package fdcr_pkg;

    // ====================================================
    // register offsets
    localparam logic [7:0] FDCR_OFS_TIMER = 8'h03;
    localparam logic [7:0] FDCR_OFS_LIMIT = 8'h04;
    localparam logic [7:0] FDCR_OFS_CAL = 8'h05;
    localparam logic [7:0] FDCR_OFS_VOLT = 8'h06;
    localparam logic [7:0] FDCR_RD_UNMAPPED = 8'h00;

    // ====================================================
    // reset values
    localparam logic [7:0] FDCR_RST_TIMER = 8'hC1;
    localparam logic [7:0] FDCR_RST_LIMIT = 8'h00;
    localparam logic [7:0] FDCR_RST_CAL = 8'h6A;
    localparam logic [7:0] FDCR_RST_VOLT = 8'h09;

    // ====================================================
    // field positions
    localparam int FDCR_B_DUR_LO = 5;
    localparam int FDCR_B_FAULT = 4;
    localparam int FDCR_B_RANGE = 3;
    localparam int FDCR_B_TRIG = 2;
    localparam int FDCR_B_STROBE = 1;
    localparam int FDCR_B_BLANK = 0;
    localparam int FDCR_B_SUPPLY = 7;
    localparam int FDCR_B_HEAT_LO = 5;
    localparam int FDCR_B_VALLEY = 4;
    localparam int FDCR_B_CALIB = 7;
    localparam int FDCR_B_PSAVE = 6;
    localparam int FDCR_B_DIR = 5;
    localparam int FDCR_B_GPIO = 4;
    localparam int FDCR_B_GTYPE = 3;
    localparam int FDCR_B_HDR = 4;

    // ====================================================
    // operating modes
    localparam logic [1:0] FDCR_MODE_OFF = 2'h0;
    localparam logic [1:0] FDCR_MODE_DC = 2'h1;
    localparam logic [1:0] FDCR_MODE_FLASH = 2'h2;
    localparam logic [1:0] FDCR_MODE_VOLT = 2'h3;

    typedef enum logic [1:0] {
        FDCR_LIM_250, FDCR_LIM_500, FDCR_LIM_1250, FDCR_LIM_1750
    } fdcr_limit_t;

    // ====================================================
    // timing: safety timer counts 0.1 ms ticks
    localparam int FDCR_CLK_PERIOD_NS = 50;
    localparam int FDCR_TICK_TIME_NS = 100000;
    localparam int FDCR_TICK_CYCLES = FDCR_TICK_TIME_NS / FDCR_CLK_PERIOD_NS;
    localparam int FDCR_PWM_PERIOD = 1000;

    // durations in 0.1 ms, index {range, code}
    function automatic logic [13:0] fdcr_duration(input logic [3:0] sel);
        logic [13:0] d;
        unique case (sel)
            4'h0: d = 14'd682;
            4'h1: d = 14'd1022;
            4'h2: d = 14'd1363;
            4'h3: d = 14'd1704;
            4'h4: d = 14'd2045;
            4'h5: d = 14'd3408;
            4'h6: d = 14'd5793;
            4'h7: d = 14'd8520;
            4'h8: d = 14'd53;
            4'h9: d = 14'd107;
            4'hA: d = 14'd160;
            4'hB: d = 14'd213;
            4'hC: d = 14'd266;
            4'hD: d = 14'd320;
            4'hE: d = 14'd373;
            4'hF: d = 14'd2077;
        endcase
        return d;
    endfunction

    // dimming duty in tenths of a percent
    function automatic logic [9:0] fdcr_duty(input logic [2:0] sel);
        logic [9:0] d;
        unique case (sel)
            3'h0: d = 10'd8;
            3'h1: d = 10'd16;
            3'h2: d = 10'd23;
            3'h3: d = 10'd31;
            3'h4: d = 10'd39;
            3'h5: d = 10'd47;
            3'h6: d = 10'd63;
            3'h7: d = 10'd86;
        endcase
        return d;
    endfunction

    // analog status in
    typedef struct packed {
        logic led_fault;
        logic in_regulation;
        logic [1:0] die_heat;
        logic headroom_ok;
        logic cal_done;
        logic [3:0] cal_result;
    } fdcr_status_t;

endpackage

// ### rtl/fdcr_regs.sv
`timescale 1ns/1ps
// Contract
// - safety timeout from 3-bit code and range bit.
// - LED fault flag set on fault, cleared by read.
// - timeout flag set on expiry, cleared on restart.
// - trigger bit picks level or edge, mode 10 only.
// - write 1 starts strobe; reads 1 while active.
// - blank enable with blank pin cuts current.
// - blank bit reports pin events since last read.
// - supply bit routes power-good or GPIO value.
// - die heat field held until read.
// - valley bit writable only before leaving shutdown.
// - valley 250/500 with select and blank high, else 1250/1750.
// - privacy codes 1-3, 5-7 drive lamp; 0, 4 off.
// - codes 5-7 pull output low; select low only.
// - codes 8-15 PWM-dim; mode 01, DC pin low only.
// - calibration bit enables; reads 0 running, 1 done.
// - power-save bit enables light-load saving.
// - shared bit reads DC pin; write sets GPIO direction.
// - GPIO value bit; type picks push-pull or open drain.
// - channel bits enable their LED inputs.
// - headroom bit captured at end of strobe.
// - voltage code reads cal result; write sets target.
// - mode code: shutdown, DC light, flash, voltage.
module fdcr_regs
    import fdcr_pkg::*;
#(
    parameter int TICK_CYCLES = FDCR_TICK_CYCLES
) (
    // clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device context and pins
    input wire logic [1:0] mode_code,
    input wire logic voltage_mode_force,
    input wire logic flash_sync_pin,
    input wire logic blank_pin,
    input wire logic high_current_select_pin,
    input wire logic dc_light_enable_pin,
    input wire logic gpio_in,
    input wire fdcr_status_t status_in,
    // controls out
    output logic strobe_active,
    output logic blank_reduce,
    output fdcr_limit_t valley_limit,
    output logic [1:0] privacy_lamp_level,
    output logic privacy_pull_down,
    output logic pwm_dim,
    output logic calibration_enable,
    output logic light_load_saving_enable,
    output logic [2:0] channel_on,
    output logic [3:0] target_voltage_code,
    output logic voltage_mode_active,
    // gpio pin
    output logic gpio_out,
    output logic gpio_oe
);

    // ====================================================
    // decode
    logic wr3, wr4, wr5, wr6, rd3, rd4;
    assign wr3 = clk_en && reg_wr && reg_addr == FDCR_OFS_TIMER;
    assign wr4 = clk_en && reg_wr && reg_addr == FDCR_OFS_LIMIT;
    assign wr5 = clk_en && reg_wr && reg_addr == FDCR_OFS_CAL;
    assign wr6 = clk_en && reg_wr && reg_addr == FDCR_OFS_VOLT;
    assign rd3 = clk_en && reg_rd && reg_addr == FDCR_OFS_TIMER;
    assign rd4 = clk_en && reg_rd && reg_addr == FDCR_OFS_LIMIT;

    // ====================================================
    // writable fields
    logic [2:0] safety_duration_code;
    logic safety_range_select, timer_trigger_edge, blank_enable;
    logic supply_ok_route, valley_limit_select, gpio_dir, gpio_drive_type;
    logic [3:0] privacy_light_code;
    logic left_shutdown;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            safety_duration_code <= FDCR_RST_TIMER[FDCR_B_DUR_LO +: 3];
            safety_range_select <= FDCR_RST_TIMER[FDCR_B_RANGE];
            timer_trigger_edge <= FDCR_RST_TIMER[FDCR_B_TRIG];
            blank_enable <= FDCR_RST_TIMER[FDCR_B_BLANK];
        end else if (wr3) begin
            safety_duration_code <= reg_wdata[FDCR_B_DUR_LO +: 3];
            safety_range_select <= reg_wdata[FDCR_B_RANGE];
            timer_trigger_edge <= reg_wdata[FDCR_B_TRIG];
            blank_enable <= reg_wdata[FDCR_B_BLANK];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_shutdown <= 1'b0;
        end else if (clk_en && mode_code != FDCR_MODE_OFF) begin
            left_shutdown <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            supply_ok_route <= FDCR_RST_LIMIT[FDCR_B_SUPPLY];
            valley_limit_select <= FDCR_RST_LIMIT[FDCR_B_VALLEY];
            privacy_light_code <= FDCR_RST_LIMIT[3:0];
        end else if (wr4) begin
            supply_ok_route <= reg_wdata[FDCR_B_SUPPLY];
            privacy_light_code <= reg_wdata[3:0];
            if (!left_shutdown) begin
                valley_limit_select <= reg_wdata[FDCR_B_VALLEY];
            end
        end
    end

    logic gpio_value;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            light_load_saving_enable <= FDCR_RST_CAL[FDCR_B_PSAVE];
            gpio_dir <= FDCR_RST_CAL[FDCR_B_DIR];
            gpio_drive_type <= FDCR_RST_CAL[FDCR_B_GTYPE];
            channel_on <= FDCR_RST_CAL[2:0];
            calibration_enable <= FDCR_RST_CAL[FDCR_B_CALIB];
        end else if (wr5) begin
            light_load_saving_enable <= reg_wdata[FDCR_B_PSAVE];
            gpio_dir <= reg_wdata[FDCR_B_DIR];
            gpio_drive_type <= reg_wdata[FDCR_B_GTYPE];
            channel_on <= reg_wdata[2:0];
            calibration_enable <= reg_wdata[FDCR_B_CALIB];
        end
    end

    // value follows pin while input
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gpio_value <= FDCR_RST_CAL[FDCR_B_GPIO];
        end else if (wr5) begin
            gpio_value <= reg_wdata[FDCR_B_GPIO];
        end else if (clk_en && !gpio_dir) begin
            gpio_value <= gpio_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            target_voltage_code <= FDCR_RST_VOLT[3:0];
        end else if (wr6) begin
            target_voltage_code <= reg_wdata[3:0];
        end
    end

    // ====================================================
    // calibration status and result
    logic cal_status;
    logic [3:0] cal_result;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_status <= 1'b0;
            cal_result <= FDCR_RST_VOLT[3:0];
        end else if (clk_en) begin
            if (wr5 && reg_wdata[FDCR_B_CALIB]) begin
                cal_status <= 1'b0;
            end else if (calibration_enable && status_in.cal_done) begin
                cal_status <= 1'b1;
                cal_result <= status_in.cal_result;
            end
        end
    end

    // ====================================================
    // safety timer and strobe
    logic trig_prev, start_req, level_drop;
    logic [11:0] tick_cnt;
    logic [13:0] tick_total;
    logic expired;
    assign start_req = (wr3 && reg_wdata[FDCR_B_STROBE])
        || (mode_code == FDCR_MODE_FLASH && flash_sync_pin
            && (!timer_trigger_edge || !trig_prev));
    assign level_drop = mode_code == FDCR_MODE_FLASH
        && !timer_trigger_edge && trig_prev && !flash_sync_pin;
    assign expired = strobe_active && tick_total
        >= fdcr_duration({safety_range_select, safety_duration_code});

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_prev <= 1'b0;
        end else if (clk_en) begin
            trig_prev <= flash_sync_pin;
        end
    end

    logic timeout_flag, regulator_headroom_ok;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_active <= 1'b0;
            tick_cnt <= '0;
            tick_total <= '0;
            timeout_flag <= 1'b0;
            regulator_headroom_ok <= 1'b0;
        end else if (clk_en) begin
            if (start_req && !strobe_active) begin
                strobe_active <= 1'b1;
                tick_cnt <= '0;
                tick_total <= '0;
                timeout_flag <= 1'b0;
            end else if (strobe_active && (expired || level_drop)) begin
                strobe_active <= 1'b0;
                timeout_flag <= timeout_flag | expired;
                regulator_headroom_ok <= status_in.headroom_ok;
            end else if (strobe_active) begin
                if (tick_cnt == 12'(TICK_CYCLES - 1)) begin
                    tick_cnt <= '0;
                    tick_total <= tick_total + 14'd1;
                end else begin
                    tick_cnt <= tick_cnt + 12'd1;
                end
            end
        end
    end

    // ====================================================
    // read-to-clear flags, set wins
    logic led_fault_flag, blank_event;
    logic [1:0] die_heat_level;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            led_fault_flag <= 1'b0;
            blank_event <= 1'b0;
        end else if (clk_en) begin
            led_fault_flag <= status_in.led_fault
                || (led_fault_flag && !rd3);
            blank_event <= blank_pin || (blank_event && !rd3);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            die_heat_level <= 2'h0;
        end else if (clk_en) begin
            if (rd4 || status_in.die_heat > die_heat_level) begin
                die_heat_level <= status_in.die_heat;
            end
        end
    end

    // ====================================================
    // read data
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= FDCR_RD_UNMAPPED;
        end else if (clk_en && reg_rd) begin
            unique case (reg_addr)
                FDCR_OFS_TIMER: reg_rdata <= {safety_duration_code,
                    led_fault_flag, timeout_flag, timer_trigger_edge,
                    strobe_active, blank_event};
                FDCR_OFS_LIMIT: reg_rdata <= {status_in.in_regulation,
                    die_heat_level, valley_limit_select,
                    privacy_light_code};
                FDCR_OFS_CAL: reg_rdata <= {cal_status,
                    light_load_saving_enable, dc_light_enable_pin,
                    gpio_value, gpio_drive_type, channel_on};
                FDCR_OFS_VOLT: reg_rdata <= {3'h0,
                    regulator_headroom_ok, cal_result};
                default: reg_rdata <= FDCR_RD_UNMAPPED;
            endcase
        end
    end

    // ====================================================
    // analog control outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blank_reduce <= 1'b0;
            valley_limit <= FDCR_LIM_1250;
            voltage_mode_active <= 1'b0;
        end else if (clk_en) begin
            blank_reduce <= blank_enable && blank_pin;
            voltage_mode_active <= mode_code == FDCR_MODE_VOLT
                || voltage_mode_force;
            if (high_current_select_pin && blank_pin) begin
                valley_limit <= valley_limit_select ? FDCR_LIM_500
                    : FDCR_LIM_250;
            end else begin
                valley_limit <= valley_limit_select ? FDCR_LIM_1750
                    : FDCR_LIM_1250;
            end
        end
    end

    // privacy lamp, codes below 8
    logic lamp_allowed;
    assign lamp_allowed = !privacy_light_code[3]
        && !(privacy_light_code[2] && high_current_select_pin);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            privacy_lamp_level <= 2'h0;
            privacy_pull_down <= 1'b0;
        end else if (clk_en) begin
            privacy_lamp_level <= lamp_allowed
                ? privacy_light_code[1:0] : 2'h0;
            privacy_pull_down <= lamp_allowed && privacy_light_code[2]
                && privacy_light_code[1:0] != 2'h0;
        end
    end

    // dimming pwm for codes 8 to 15
    logic [9:0] pwm_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_cnt <= '0;
            pwm_dim <= 1'b0;
        end else if (clk_en) begin
            pwm_cnt <= (pwm_cnt == 10'(FDCR_PWM_PERIOD - 1))
                ? 10'd0 : pwm_cnt + 10'd1;
            pwm_dim <= privacy_light_code[3]
                && mode_code == FDCR_MODE_DC && !dc_light_enable_pin
                && pwm_cnt < fdcr_duty(privacy_light_code[2:0]);
        end
    end

    // ====================================================
    // gpio pin drive
    logic gpio_src;
    assign gpio_src = supply_ok_route ? gpio_value
        : status_in.in_regulation;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gpio_out <= 1'b0;
            gpio_oe <= 1'b0;
        end else if (clk_en) begin
            gpio_out <= gpio_drive_type ? 1'b0 : gpio_src;
            gpio_oe <= gpio_dir && (!gpio_drive_type || !gpio_src);
        end
    end

endmodule

// ### tb/fdcr_regs_assertions.sv
`timescale 1ns/1ps
module fdcr_regs_chk
    import fdcr_pkg::*;
(
    // clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    // device context
    input wire logic [1:0] mode_code,
    input wire logic voltage_mode_force,
    input wire logic blank_pin,
    input wire logic high_current_select_pin,
    // controls
    input wire logic strobe_active,
    input wire logic blank_reduce,
    input wire fdcr_limit_t valley_limit,
    input wire logic privacy_pull_down,
    input wire logic calibration_enable,
    input wire logic light_load_saving_enable,
    input wire logic [2:0] channel_on,
    input wire logic [3:0] target_voltage_code,
    input wire logic voltage_mode_active,
    input wire logic gpio_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==================================================
    // helper state
    logic ever_on;
    logic [7:0] wd_q;
    always_ff @(posedge clk) begin
        if (sys_rst)
            ever_on <= 1'b0;
        else if (clk_en && mode_code != FDCR_MODE_OFF)
            ever_on <= 1'b1;
    end
    always_ff @(posedge clk) begin
        wd_q <= reg_wdata;
    end
    sequence s_wr(logic [7:0] a);
        clk_en && reg_wr && reg_addr == a;
    endsequence
    // ==================================================
    // properties
    a_strobe_start: assert property (
        s_wr(FDCR_OFS_TIMER) ##0 reg_wdata[FDCR_B_STROBE] && !strobe_active
        |=> strobe_active) else $error("strobe did not start");
    a_blank_off: assert property (
        s_wr(FDCR_OFS_TIMER) ##0 !reg_wdata[FDCR_B_BLANK] |=> ##1 !blank_reduce
    ) else $error("blank reduce while disabled");
    a_valley_lock: assert property (
        ever_on ##0 s_wr(FDCR_OFS_LIMIT) |=> ##1 $stable(valley_limit[0])
    ) else $error("valley select changed");
    a_valley_map: assert property (
        clk_en |=> valley_limit[1] ==
            !($past(high_current_select_pin) && $past(blank_pin))
    ) else $error("valley limit range wrong");
    a_pull_hc: assert property (
        privacy_pull_down |-> !$past(high_current_select_pin)
    ) else $error("pull down with select");
    a_volt_mode: assert property (
        clk_en |=> voltage_mode_active == ($past(mode_code) == FDCR_MODE_VOLT
            || $past(voltage_mode_force))
    ) else $error("voltage mode flag wrong");
    a_gpio_input: assert property (
        s_wr(FDCR_OFS_CAL) ##0 !reg_wdata[FDCR_B_DIR] |=> ##1 !gpio_oe
    ) else $error("gpio driven while input");
    a_target_wr: assert property (
        s_wr(FDCR_OFS_VOLT) |=> target_voltage_code == wd_q[3:0]
    ) else $error("target code not written");
    a_cal_write: assert property (
        s_wr(FDCR_OFS_CAL) |=> {calibration_enable, light_load_saving_enable,
            channel_on} == {wd_q[7:6], wd_q[2:0]}
    ) else $error("control bits not written");
endmodule

bind fdcr_regs fdcr_regs_chk u_fdcr_regs_chk (
    .clk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .mode_code,
    .voltage_mode_force, .blank_pin, .high_current_select_pin,
    .strobe_active, .blank_reduce, .valley_limit, .privacy_pull_down,
    .calibration_enable, .light_load_saving_enable, .channel_on,
    .target_voltage_code, .voltage_mode_active, .gpio_oe
);

// ### tb/fdcr_host.sv
`timescale 1ns/1ps
module fdcr_host
    import fdcr_pkg::*;
(
    // clock
    input wire logic clk,
    // register access
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    end
    // one-cycle write; data inverted after
    task automatic wr(input logic [7:0] a, v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~v;
    endtask
    // data taken a cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
endmodule

// ### tb/tb_flash_driver_control_registers.sv
`timescale 1ns/1ps
module tb_flash_driver_control_registers
    import fdcr_pkg::*;
;
    localparam int TC = 2;
    logic clk, sys_rst, reg_wr, reg_rd, clk_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] mode_code, privacy_lamp_level;
    logic voltage_mode_force, flash_sync_pin, blank_pin, dc_light_enable_pin;
    logic high_current_select_pin, gpio_in, strobe_active, blank_reduce;
    logic privacy_pull_down, pwm_dim, calibration_enable, gpio_out, gpio_oe;
    logic light_load_saving_enable, voltage_mode_active;
    logic [2:0] channel_on;
    logic [3:0] target_voltage_code;
    fdcr_status_t st;
    fdcr_limit_t valley_limit;
    int err_count, n_tests, n;

    fdcr_host u_fdcr_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata);
    fdcr_regs #(.TICK_CYCLES(TC)) u_fdcr_regs (
        .clk, .sys_rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .mode_code, .voltage_mode_force, .flash_sync_pin,
        .blank_pin, .high_current_select_pin, .dc_light_enable_pin, .gpio_in,
        .status_in(st), .strobe_active, .blank_reduce, .valley_limit,
        .privacy_lamp_level, .privacy_pull_down, .pwm_dim,
        .calibration_enable, .light_load_saving_enable, .channel_on,
        .target_voltage_code, .voltage_mode_active, .gpio_out, .gpio_oe);

    // ==================================================
    // helpers
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int lo, hi, g);
        n_tests++;
        if (g < lo || g > hi) begin
            err_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, v);
        u_fdcr_host.wr(a, v);
    endtask
    task automatic pin(input logic [1:0] e);
        chk("gpio pin", {6'h0, e}, {6'h0, gpio_oe, gpio_out});
    endtask
    task automatic sb(input logic e);
        chk("strobe", {7'h0, e}, {7'h0, strobe_active});
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_fdcr_host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic span(output int m);
        m = 0;
        while (strobe_active === 1'b1 && m < 5000) begin
            @(negedge clk);
            m++;
        end
    endtask
    task automatic pwm(input logic [3:0] c, input int e);
        int k = 0;
        wr(FDCR_OFS_LIMIT, {4'h1, c});
        cyc(1000);
        repeat (1000) begin
            @(negedge clk);
            k += (pwm_dim === 1'b1);
        end
        chk_n("pwm", e, e, k);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        stop_test();
    end

    // ==================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        {mode_code, voltage_mode_force, flash_sync_pin, blank_pin} = '0;
        {high_current_select_pin, dc_light_enable_pin, gpio_in} = '0;
        st = '0;
        err_count = 0;
        n_tests = 0;
        repeat (9) @(negedge clk);
        sys_rst = 1'b0;
        chk("reset", 8'hA9, {light_load_saving_enable, channel_on,
            target_voltage_code});
        chk("valley", 8'h02, 8'(valley_limit));
        rc(FDCR_OFS_TIMER, 8'hC0);
        rc(FDCR_OFS_LIMIT, 8'h00);
        rc(FDCR_OFS_CAL, 8'h4A);
        rc(FDCR_OFS_VOLT, 8'h09);
        rc(8'h07, FDCR_RD_UNMAPPED);
        // valley limit, blanking
        wr(FDCR_OFS_LIMIT, 8'h10);
        cyc(2);
        chk("valley", 8'h03, 8'(valley_limit));
        {high_current_select_pin, blank_pin} = 2'b11;
        cyc(2);
        chk("valley", 8'h01, 8'(valley_limit));
        chk("blank reduce", 8'h01, 8'(blank_reduce));
        {high_current_select_pin, blank_pin} = 2'b00;
        rc(FDCR_OFS_TIMER, 8'hC1);
        rc(FDCR_OFS_TIMER, 8'hC0);
        mode_code = FDCR_MODE_DC;
        cyc(2);
        mode_code = FDCR_MODE_OFF;
        wr(FDCR_OFS_LIMIT, 8'h00);
        rc(FDCR_OFS_LIMIT, 8'h10);
        // read-only bits, target, clock enable
        voltage_mode_force = 1'b1;
        cyc(2);
        chk("voltage mode", 8'h01, 8'(voltage_mode_active));
        wr(FDCR_OFS_VOLT, 8'hF0);
        chk("target", 8'h00, 8'(target_voltage_code));
        clk_en = 1'b0;
        wr(FDCR_OFS_VOLT, 8'h0F);
        clk_en = 1'b1;
        chk("frozen", 8'h00, 8'(target_voltage_code));
        voltage_mode_force = 1'b0;
        rc(FDCR_OFS_VOLT, 8'h09);
        wr(FDCR_OFS_LIMIT, 8'h70);
        rc(FDCR_OFS_LIMIT, 8'h10);
        wr(FDCR_OFS_TIMER, 8'hD0);
        rc(FDCR_OFS_TIMER, 8'hC0);
        // die heat and fault flags
        st.die_heat = 2'h3;
        cyc(1);
        st.die_heat = 2'h1;
        rc(FDCR_OFS_LIMIT, 8'h70);
        st.die_heat = 2'h0;
        rc(FDCR_OFS_LIMIT, 8'h30);
        rc(FDCR_OFS_LIMIT, 8'h10);
        st.led_fault = 1'b1;
        cyc(1);
        st.led_fault = 1'b0;
        rc(FDCR_OFS_TIMER, 8'hD0);
        rc(FDCR_OFS_TIMER, 8'hC0);
        // calibration, gpio
        {dc_light_enable_pin, gpio_in} = 2'b11;
        wr(FDCR_OFS_CAL, 8'h85);
        cyc(2);
        chk("controls", 8'h15, {3'h0, calibration_enable,
            light_load_saving_enable, channel_on});
        chk("gpio oe", 8'h00, 8'(gpio_oe));
        rc(FDCR_OFS_CAL, 8'h35);
        st.cal_result = 4'h5;
        st.cal_done = 1'b1;
        cyc(1);
        st.cal_done = 1'b0;
        rc(FDCR_OFS_CAL, 8'hB5);
        rc(FDCR_OFS_VOLT, 8'h05);
        wr(FDCR_OFS_CAL, 8'h30);
        wr(FDCR_OFS_LIMIT, 8'h90);
        cyc(2);
        pin(2'h3);
        wr(FDCR_OFS_CAL, 8'h38);
        cyc(2);
        pin(2'h0);
        wr(FDCR_OFS_LIMIT, 8'h10);
        cyc(2);
        pin(2'h2);
        st.in_regulation = 1'b1;
        cyc(3);
        pin(2'h0);
        rc(FDCR_OFS_LIMIT, 8'h90);
        // privacy indicator codes
        for (int i = 0; i < 8; i++) begin
            wr(FDCR_OFS_LIMIT, 8'h10 | 8'(i));
            cyc(2);
            chk("privacy", {5'h0, i[2] && i[1:0] != 2'h0, 2'(i)},
                {5'h0, privacy_pull_down, privacy_lamp_level});
        end
        high_current_select_pin = 1'b1;
        wr(FDCR_OFS_LIMIT, 8'h15);
        cyc(2);
        chk("privacy", 8'h00, {5'h0, privacy_pull_down,
            privacy_lamp_level});
        high_current_select_pin = 1'b0;
        dc_light_enable_pin = 1'b0;
        mode_code = FDCR_MODE_DC;
        pwm(4'h8, 8);
        pwm(4'hF, 86);
        dc_light_enable_pin = 1'b1;
        pwm(4'h8, 0);
        dc_light_enable_pin = 1'b0;
        mode_code = FDCR_MODE_OFF;
        // strobe, safety timer
        st.headroom_ok = 1'b1;
        wr(FDCR_OFS_TIMER, 8'h0A);
        sb(1'b1);
        span(n);
        chk_n("strobe len", 53 * TC - 2, 53 * TC + 2, n);
        rc(FDCR_OFS_TIMER, 8'h08);
        rc(FDCR_OFS_VOLT, 8'h15);
        wr(FDCR_OFS_TIMER, 8'h02);
        rc(FDCR_OFS_TIMER, 8'h02);
        wr(FDCR_OFS_TIMER, 8'h00);
        sb(1'b1);
        span(n);
        chk_n("strobe len", 682 * TC - 10, 682 * TC + 2, n);
        // trigger pin
        mode_code = FDCR_MODE_FLASH;
        wr(FDCR_OFS_TIMER, 8'h08);
        flash_sync_pin = 1'b1;
        cyc(3);
        sb(1'b1);
        flash_sync_pin = 1'b0;
        cyc(3);
        sb(1'b0);
        wr(FDCR_OFS_TIMER, 8'h0C);
        flash_sync_pin = 1'b1;
        cyc(3);
        flash_sync_pin = 1'b0;
        cyc(3);
        sb(1'b1);
        cyc(120);
        mode_code = FDCR_MODE_DC;
        flash_sync_pin = 1'b1;
        cyc(3);
        sb(1'b0);
        flash_sync_pin = 1'b0;
        stop_test();
    end
endmodule
